// ===== design/bbgd_pkg.sv
// Package: shared constants for the board bus glue decode and its user-side partner
package bbgd_pkg;

    // ****************************************
    // Address decode
    // ****************************************
    localparam int          ADDR_W         = 24;
    localparam int          SEG_NUM        = 5;
    localparam logic [7:0]  SEG_BASE_A     = 8'h02;
    localparam logic [7:0]  SEG_BASE_B     = 8'h04;
    localparam logic [7:0]  SEG_BASE_C     = 8'h05;
    localparam logic [7:0]  SEG_BASE_D     = 8'h06;
    localparam logic [7:0]  SEG_BASE_F     = 8'h07;
    localparam logic [7:0]  SYNC_PAGE      = 8'h03;

    // ****************************************
    // Interrupt
    // ****************************************
    localparam logic [2:0]  USER_IRQ_LEVEL = 3'h4;
    localparam logic [7:0]  AUTOVEC_NUM    = 8'h1c;
    localparam logic [2:0]  FC_INT_ACK     = 3'h7;

    // ****************************************
    // Timing and idle interrupt level
    // ****************************************
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          SYNC_CLK_HZ    = 400_000;
    localparam int          SYNC_HALF      = CLK_HZ / SYNC_CLK_HZ / 2;
    localparam logic [5:0]  SYNC_HALF_CNT  = 6'(SYNC_HALF - 1);
    localparam logic [2:0]  IRQ_NONE       = 3'h0;

endpackage : bbgd_pkg

// ===== design/bbgd_if.sv
// Interface: processor-board bus seen by the glue logic and by user logic
`timescale 1ns/100ps
interface bbgd_if;
    logic [bbgd_pkg::SEG_NUM-1:0] seg_enable_n;
    logic                         sync_page_sel;
    logic                         periph_addr_valid_n;
    logic                         sync_clk;
    logic                         xfer_ack_n;
    logic                         ext_ack_n_o;
    logic                         ext_ack_n_oe_n;
    logic                         user_irq_n;
    logic [2:0]                   irq_level;
    logic                         autovec;
    logic [7:0]                   vec_num;
    logic [7:0]                   data_lo_o;
    logic                         data_lo_oe_n;

    modport glue
    (
        output seg_enable_n, sync_page_sel, periph_addr_valid_n, sync_clk,
        output xfer_ack_n, irq_level, autovec, vec_num,
        input  ext_ack_n_o, ext_ack_n_oe_n, user_irq_n
    );
    modport user
    (
        input  seg_enable_n, sync_page_sel, periph_addr_valid_n, sync_clk, xfer_ack_n,
        output ext_ack_n_o, ext_ack_n_oe_n, user_irq_n, data_lo_o, data_lo_oe_n
    );
endinterface : bbgd_if

// ===== design/bbgd_glue.sv
// Module: board glue for segment decode, sync page, acknowledge and user interrupt
// Notes on behaviour
// - Five low segment enables, one per segment
// - Enables valid only with strobe and decode
// - User never drives combined ack directly
// - User interrupts only via level four
// - Sync page request peripheral address valid
// - Processor aligns to sync clock, asserts valid
// - Page select needs page, valid, low strobe
// - Sync peripherals use low eight data bits
// - Low user request gives level four
// - Level four acknowledge answers autovector 28
// - User holds request until software clears
// - Software installs vector at 0x000070
// - User request pin is input only
`timescale 1ns/100ps
module bbgd_glue
(
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          clk_en,
    input  wire logic [bbgd_pkg::ADDR_W-1:0]   addr,
    input  wire logic                          addr_strobe_n,
    input  wire logic                          low_byte_strobe_n,
    input  wire logic                          sync_cycle_valid_n,
    input  wire logic [2:0]                    func_code,
    input  wire logic                          timer_chip_ack_n,
    input  wire logic                          timer_chip_ack_oe_n,
    input  wire logic                          ram_ack_n,
    input  wire logic                          rom_ack_n,
    bbgd_if.glue                               bus
);

    // ****************************************
    // Decode
    // ****************************************
    // Address high byte selects the 64K segment
    wire logic [7:0]                  seg_byte = addr[23:16];
    wire logic                        strobe   = ~addr_strobe_n;
    wire logic [7:0]                  seg_base [bbgd_pkg::SEG_NUM];
    wire logic [bbgd_pkg::SEG_NUM-1:0] seg_hit;
    wire logic                        page_hit;
    wire logic                        page_sel;
    wire logic                        user_ack_join;
    wire logic                        ack_all_n;
    wire logic                        int_ack;

    assign seg_base[0] = bbgd_pkg::SEG_BASE_A;
    assign seg_base[1] = bbgd_pkg::SEG_BASE_B;
    assign seg_base[2] = bbgd_pkg::SEG_BASE_C;
    assign seg_base[3] = bbgd_pkg::SEG_BASE_D;
    assign seg_base[4] = bbgd_pkg::SEG_BASE_F;

    // Each enable qualified by the strobe, so nothing lingers between cycles
    genvar g;
    generate
        for (g = 0; g < bbgd_pkg::SEG_NUM; g++)
        begin : g_seg
            assign seg_hit[g] = strobe && (seg_byte == seg_base[g]);
        end
    endgenerate

    assign page_hit = strobe && (seg_byte == bbgd_pkg::SYNC_PAGE);
    assign page_sel = page_hit && !sync_cycle_valid_n && !low_byte_strobe_n;

    // Shared point: low when the enabled timer driver or the enabled user open-drain pulls low, else pull-up
    assign user_ack_join = (!timer_chip_ack_oe_n && !timer_chip_ack_n) ||
                           (!bus.ext_ack_n_oe_n && !bus.ext_ack_n_o) ? 1'b0 : 1'b1;
    assign ack_all_n     = user_ack_join & ram_ack_n & rom_ack_n;
    assign int_ack       = strobe && (func_code == bbgd_pkg::FC_INT_ACK) &&
                           (addr[3:1] == bbgd_pkg::USER_IRQ_LEVEL);

    // ****************************************
    // Registered outputs
    // ****************************************
    logic [bbgd_pkg::SEG_NUM-1:0] seg_en_n_q;
    logic                         page_sel_q;
    logic                         pav_n_q;
    logic                         ack_q;
    logic [2:0]                   irq_q;
    logic                         autovec_q;
    logic [5:0]                   div_cnt;
    logic                         sync_clk_q;

    // Outputs one clock after the bus inputs; 50 ns is small against bus timing
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            seg_en_n_q <= '1;
            page_sel_q <= 1'b0;
            pav_n_q    <= 1'b1;
            ack_q      <= 1'b1;
            irq_q      <= bbgd_pkg::IRQ_NONE;
            autovec_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            seg_en_n_q <= ~seg_hit;
            page_sel_q <= page_sel;
            pav_n_q    <= ~(page_hit || int_ack);
            ack_q      <= ack_all_n;
            irq_q      <= bus.user_irq_n ? bbgd_pkg::IRQ_NONE
                                         : bbgd_pkg::USER_IRQ_LEVEL;
            autovec_q  <= int_ack;
        end
    end

    // Sync clock divider, 20 MHz down to 400 kHz
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            div_cnt    <= 6'h00;
            sync_clk_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (div_cnt == bbgd_pkg::SYNC_HALF_CNT)
            begin
                div_cnt    <= 6'h00;
                sync_clk_q <= ~sync_clk_q;
            end
            else
            begin
                div_cnt <= div_cnt + 6'h01;
            end
        end
    end

    assign bus.seg_enable_n        = seg_en_n_q;
    assign bus.sync_page_sel       = page_sel_q;
    assign bus.periph_addr_valid_n = pav_n_q;
    assign bus.xfer_ack_n          = ack_q;
    assign bus.irq_level           = irq_q;
    assign bus.autovec             = autovec_q;
    assign bus.vec_num             = bbgd_pkg::AUTOVEC_NUM;
    assign bus.sync_clk            = sync_clk_q;

endmodule : bbgd_glue

// ===== design/bbgd_user.sv
// Module: user-side peripheral logic on the board bus
`timescale 1ns/100ps
module bbgd_user
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       async_sel,
    input  wire logic       ack_req,
    input  wire logic [7:0] rd_data,
    input  wire logic       irq_raise,
    input  wire logic       irq_clear,
    output logic            sync_strobe,
    output logic            irq_pending,
    bbgd_if.user            bus
);

    // ****************************************
    // Acknowledge and data
    // ****************************************
    logic       ack_drive;
    logic       irq_q;
    logic       strobe_q;
    logic [7:0] data_q;
    logic       data_en;

    // Acknowledge only on the shared point, never on the combined line
    wire logic next_ack = ack_req && !bus.seg_enable_n[0] && async_sel;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ack_drive <= 1'b0;
            strobe_q  <= 1'b0;
            data_q    <= 8'h00;
            data_en   <= 1'b0;
        end
        else if (clk_en)
        begin
            ack_drive <= next_ack;
            strobe_q  <= bus.sync_page_sel;
            data_q    <= rd_data;
            data_en   <= bus.sync_page_sel;
        end
    end

    // Request held until software clears; raise wins over clear
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq_q <= 1'b0;
        else if (clk_en)
            irq_q <= irq_raise || (irq_q && !irq_clear);
    end

    assign bus.ext_ack_n_o    = 1'b0;
    assign bus.ext_ack_n_oe_n = ~ack_drive;
    assign bus.user_irq_n     = ~irq_q;
    assign bus.data_lo_o      = data_q;
    assign bus.data_lo_oe_n   = ~data_en;
    assign sync_strobe        = strobe_q;
    assign irq_pending        = irq_q;

endmodule : bbgd_user

// ===== test/bbgd_props.sv
// Checker: relations between the glue outputs on the shared bus
`timescale 1ns/100ps
module bbgd_props
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [4:0] seg_enable_n,
    input wire logic       sync_page_sel,
    input wire logic       periph_addr_valid_n,
    input wire logic       sync_clk,
    input wire logic       xfer_ack_n,
    input wire logic       ext_ack_n_o,
    input wire logic       ext_ack_n_oe_n,
    input wire logic       user_irq_n,
    input wire logic [2:0] irq_level,
    input wire logic       autovec,
    input wire logic [7:0] vec_num
);
    // ****************
    // Properties
    // ****************
    logic [5:0] cnt;
    logic       last;
    logic       seen;
    wire        flip = sync_clk != last;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Cycles since the last slow clock edge; first half after reset is not judged
    always_ff @(posedge clock)
    begin
        cnt  <= (!rst_n || flip) ? 6'h00 : cnt + 6'h01;
        seen <= rst_n && (seen || flip);
        last <= sync_clk;
    end
    a_sync_half: assert property (seen && flip |-> cnt == bbgd_pkg::SYNC_HALF_CNT)
        else $error("slow clock half period wrong");
    a_sync_runs: assert property (seen |-> cnt <= bbgd_pkg::SYNC_HALF_CNT)
        else $error("slow clock stopped");
    a_seg_one_hot: assert property ($onehot0(~seg_enable_n))
        else $error("two segment enables active");
    a_page_no_seg: assert property (sync_page_sel |-> &seg_enable_n)
        else $error("page select with segment enable");
    a_page_has_pav: assert property (sync_page_sel |-> !periph_addr_valid_n)
        else $error("page select without strobe decode");
    a_user_ack_join: assert property (!ext_ack_n_oe_n && !ext_ack_n_o |=> !xfer_ack_n)
        else $error("user ack not joined");
    a_irq_level_on: assert property (!user_irq_n |=> irq_level == bbgd_pkg::USER_IRQ_LEVEL)
        else $error("user request not at level four");
    a_irq_level_off: assert property (user_irq_n |=> irq_level == bbgd_pkg::IRQ_NONE)
        else $error("level shown without request");
    a_vec_fixed: assert property (autovec |-> vec_num == bbgd_pkg::AUTOVEC_NUM)
        else $error("wrong autovector number");
endmodule : bbgd_props

// ===== test/board_bus_glue_decode_bench.sv
// Bench: drives both ends of the board bus glue and checks the decode
`timescale 1ns/100ps
module board_bus_glue_decode_bench;
    // ****************
    // Stimulus and checks
    // ****************
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic [23:0] addr = 24'h000000;
    logic        addr_strobe_n = 1'b1;
    logic        low_byte_strobe_n = 1'b1;
    logic        sync_cycle_valid_n = 1'b1;
    logic [2:0]  func_code = 3'h5;
    logic        timer_chip_ack_n = 1'b1;
    logic        timer_chip_ack_oe_n = 1'b1;
    logic        ram_ack_n = 1'b1;
    logic        rom_ack_n = 1'b1;
    logic        async_sel = 1'b0;
    logic        ack_req = 1'b0;
    logic [7:0]  rd_data = 8'h00;
    logic        irq_raise = 1'b0;
    logic        irq_clear = 1'b0;
    logic        irq_pending;
    logic [31:0] seed = 32'h000002d2;
    logic [11:0] q[$];
    logic [7:0]  pages [9] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h03, 8'h00, 8'h08, 8'hff};
    int          fails = 0;
    int          comparisons = 0;
    int          cycles = 0;
    bbgd_if      bus ();
    bbgd_glue u_bbgd_glue (.clock, .rst_n, .clk_en, .addr, .addr_strobe_n, .low_byte_strobe_n,
        .sync_cycle_valid_n, .func_code, .timer_chip_ack_n, .timer_chip_ack_oe_n, .ram_ack_n,
        .rom_ack_n, .bus(bus.glue));
    bbgd_user u_bbgd_user (.clock, .rst_n, .clk_en, .async_sel, .ack_req, .rd_data, .irq_raise,
        .irq_clear, .sync_strobe(), .irq_pending, .bus(bus.user));
    bbgd_props u_bbgd_props (.clock, .rst_n, .seg_enable_n(bus.seg_enable_n),
        .sync_page_sel(bus.sync_page_sel), .periph_addr_valid_n(bus.periph_addr_valid_n),
        .sync_clk(bus.sync_clk), .xfer_ack_n(bus.xfer_ack_n), .ext_ack_n_o(bus.ext_ack_n_o),
        .ext_ack_n_oe_n(bus.ext_ack_n_oe_n), .user_irq_n(bus.user_irq_n),
        .irq_level(bus.irq_level), .autovec(bus.autovec), .vec_num(bus.vec_num));
    always #25 clock = ~clock;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Expected outputs one cycle on: segments, page, pav, ack, level, autovec
    function automatic logic [11:0] expect_now();
        logic [7:0] pg;
        logic       as;
        logic       ia;
        logic [4:0] seg;
        pg  = addr[23:16];
        as  = !addr_strobe_n;
        ia  = as && func_code == bbgd_pkg::FC_INT_ACK && addr[3:1] == bbgd_pkg::USER_IRQ_LEVEL;
        seg = {pg == bbgd_pkg::SEG_BASE_F, pg == bbgd_pkg::SEG_BASE_D, pg == bbgd_pkg::SEG_BASE_C,
               pg == bbgd_pkg::SEG_BASE_B, pg == bbgd_pkg::SEG_BASE_A} & {5{as}};
        return {~seg, as && pg == bbgd_pkg::SYNC_PAGE && !sync_cycle_valid_n && !low_byte_strobe_n,
                !(ia || as && pg == bbgd_pkg::SYNC_PAGE),
                (timer_chip_ack_oe_n | timer_chip_ack_n) & ram_ack_n & rom_ack_n, 3'h0, ia};
    endfunction : expect_now
    task automatic check(input logic [11:0] want, input logic [11:0] got);
        comparisons++;
        if (got !== want)
        begin
            fails++;
            $display("ERROR %0t want %h got %h", $time, want, got);
        end
    endtask : check
    task automatic wait_lvl(input logic [2:0] lvl);
        for (int k = 0; k < 8 && bus.irq_level !== lvl; k++)
            @(negedge clock);
        check({9'h000, lvl}, {9'h000, bus.irq_level});
    endtask : wait_lvl
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // Oldest note against each settled result
    always @(posedge clock)
    begin
        #1;
        if (q.size() > 0)
            check(q.pop_front(), {bus.seg_enable_n, bus.sync_page_sel, bus.periph_addr_valid_n,
                  bus.xfer_ack_n, bus.irq_level, bus.autovec});
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            summarize();
        end
    end
    initial
    begin
        logic [31:0] r;
        int          n;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        for (int i = 0; i < 200; i++)
        begin
            @(negedge clock);
            r = rnd();
            addr = {pages[r[7:4] % 4'h9], r[31:16]};
            {addr_strobe_n, low_byte_strobe_n, sync_cycle_valid_n} = r[10:8];
            func_code = (r[13:11] == 3'h7) ? 3'h1 : r[13:11];
            {timer_chip_ack_n, timer_chip_ack_oe_n, ram_ack_n, rom_ack_n} = r[3:0];
            rd_data = r[23:16];
            q.push_back(expect_now());
        end
        $display("decode sweep done");
        // Acknowledge cycles for every level; only level four is ours
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clock);
            func_code = 3'h7;
            addr_strobe_n = 1'b0;
            addr = {20'hfffff, i[2:0], 1'b1};
            q.push_back(expect_now());
        end
        @(negedge clock);
        {addr_strobe_n, func_code, timer_chip_ack_oe_n, ram_ack_n, rom_ack_n} = 7'h7b;
        q.push_back(expect_now());
        check(12'h070, {2'h0, bus.vec_num, 2'h0});
        $display("interrupt acknowledge done");
        // User ack on the shared open-drain point, inside segment A so it may answer
        @(negedge clock);
        addr = 24'h020000;
        addr_strobe_n = 1'b0;
        timer_chip_ack_oe_n = 1'b1;
        async_sel = 1'b1;
        ack_req = 1'b1;
        repeat (4) @(negedge clock);
        check(12'h000, {11'h000, bus.xfer_ack_n});
        {async_sel, ack_req, addr_strobe_n} = 3'b001;
        irq_raise = 1'b1;
        @(negedge clock);
        irq_raise = 1'b0;
        wait_lvl(bbgd_pkg::USER_IRQ_LEVEL);
        repeat (30) @(negedge clock);
        check(12'h001, {11'h000, irq_pending});
        irq_clear = 1'b1;
        @(negedge clock);
        irq_clear = 1'b0;
        wait_lvl(bbgd_pkg::IRQ_NONE);
        $display("user interrupt done");
        n = 0;
        @(posedge bus.sync_clk);
        while (bus.sync_clk === 1'b1)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check(12'(bbgd_pkg::SYNC_HALF), n[11:0]);
        $display("slow clock done");
        summarize();
    end
endmodule : board_bus_glue_decode_bench
